// >>> pkg/drive_ctrl_map.svh
`ifndef DRIVE_CTRL_MAP_SVH
`define DRIVE_CTRL_MAP_SVH
`define A_CTRL 8'h00
`define A_MODE 8'h04
`define A_DROOP_SCALE 8'h08
`define A_MAX_SPEED 8'h0c
`define A_DEV_THR 8'h10
`define A_DEV_HYST 8'h14
`define A_DEV_DELAY 8'h18
`define A_BRAKE_TIME 8'h1c
`define A_SS_THR 8'h20
`define A_SS_TIME 8'h24
`define A_QS_RAMP 8'h28
`define A_TRQ_LIM 8'h2c
`define A_INERTIA 8'h30
`define A_DROOP_RED 8'h34
`define A_SEL_SPEED 8'h38
`define A_STATUS 8'h3c
`define C_DROOP_EN 0
`define C_DROOP_SRC 1
`define C_CHANGEOVER 2
`define C_NORMAL 3
`define C_COAST 4
`define C_QUICK 5
`define C_BRAKE_CFG 6
`define C_FAULT_QUICK 7
`define C_SRC_LO 8
`define C_SRC_HI 9
`define C_CLEAR 10
`define MODE_SLESS 5'h14
`define MODE_ENC 5'h15
`define MODE_TRQ_A 5'h16
`define MODE_TRQ_B 5'h17
`define RST_MODE 5'h15
`define RST_CTRL 32'h0000_0000
`define RST_TRQ_LIM 16'h4000
`define RST_MAX_SPEED 16'h7000
`define DROOP_SHIFT 8
`define MS_NS 1000000
`define CLK_NS 40
`endif

// >>> pkg/drive_ctrl_pkg.sv
package drive_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_RUN, ST_RAMP, ST_FOLLOW, ST_BRAKE, ST_OFF
   } stop_state_type;
   typedef struct packed {
      stop_state_type st;
      logic [14:0] ms_cnt;
      logic ms_tick;
      logic [15:0] ss_tmr;
      logic [15:0] brk_tmr;
      logic [15:0] dev_tmr;
      logic in_tol;
      logic fault;
      logic inhibit;
      logic standstill;
      logic signed [15:0] ramp_sp;
      logic signed [15:0] int_sp;
      logic signed [31:0] int_acc;
      logic signed [15:0] droop_red;
      logic signed [15:0] sel_spd;
      logic signed [15:0] spd_set;
      logic signed [15:0] trq;
      logic signed [15:0] model_spd;
      logic [31:0] ctrl;
      logic [4:0] mode;
      logic [15:0] droop_scale;
      logic [15:0] max_speed;
      logic [15:0] dev_thr;
      logic [15:0] dev_hyst;
      logic [15:0] dev_delay;
      logic [15:0] brk_time;
      logic [15:0] ss_thr;
      logic [15:0] ss_time;
      logic [15:0] qs_ramp;
      logic [15:0] trq_lim;
      logic [23:0] inertia;
      logic pulse_en;
      logic brake_close;
      logic trq_mode;
      logic lim_red;
      logic ack;
      logic [31:0] dat;
   } state_type;
endpackage

// >>> rtl/drive_ctrl.sv
`include "drive_ctrl_map.svh"
module drive_ctrl #(
   parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic signed [15:0] speed_setpoint_i,
   input wire logic signed [15:0] unsmoothed_speed_actual_i,
   input wire logic signed [15:0] external_speed_i,
   input wire logic signed [15:0] model_speed_smoothed_i,
   input wire logic signed [15:0] encoder_speed_i,
   input wire logic signed [15:0] speed_ctrl_torque_i,
   input wire logic signed [15:0] torque_setpoint_input_i,
   input wire logic signed [15:0] supplementary_torque_input_i,
   input wire logic open_loop_i,
   output logic signed [15:0] speed_setpoint_o,
   output logic signed [15:0] speed_actual_o,
   output logic signed [15:0] motor_model_speed_o,
   output logic signed [15:0] torque_demand_o,
   output logic torque_mode_o,
   output logic pulse_enable_o,
   output logic brake_close_o,
   output logic switch_on_inhibit_o,
   output logic fault_o
);
   if (MS_CYCLES < 2 || MS_CYCLES > 32767) begin : g_chk
      $error("MS_CYCLES out of range");
   end

   localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

   drive_ctrl_pkg::state_type q, d;

   logic wr, clr, direct, over, over_spd, under_spd, integ, stand;
   logic co_req, qs_req, fol_req;
   logic signed [15:0] load, act, base;
   logic signed [32:0] prod;
   logic signed [16:0] diff, adiff, tsum, upper, lower;
   logic signed [31:0] tdiv;
   logic [31:0] wd, rd;

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic signed [15:0] sat(input logic signed [16:0] v);
      if (v > 17'sh07fff) begin
         return 16'sh7fff;
      end else if (v < -17'sh08000) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction

   always_comb begin
      d = q;
      wr = wb_cyc_i && wb_stb_i && !q.ack;
      d.ack = wr;
      // register read mux, unmapped reads as zero
      unique case (wb_adr_i)
         `A_CTRL: rd = q.ctrl;
         `A_MODE: rd = {27'h0000000, q.mode};
         `A_DROOP_SCALE: rd = {16'h0000, q.droop_scale};
         `A_MAX_SPEED: rd = {16'h0000, q.max_speed};
         `A_DEV_THR: rd = {16'h0000, q.dev_thr};
         `A_DEV_HYST: rd = {16'h0000, q.dev_hyst};
         `A_DEV_DELAY: rd = {16'h0000, q.dev_delay};
         `A_BRAKE_TIME: rd = {16'h0000, q.brk_time};
         `A_SS_THR: rd = {16'h0000, q.ss_thr};
         `A_SS_TIME: rd = {16'h0000, q.ss_time};
         `A_QS_RAMP: rd = {16'h0000, q.qs_ramp};
         `A_TRQ_LIM: rd = {16'h0000, q.trq_lim};
         `A_INERTIA: rd = {8'h00, q.inertia};
         `A_DROOP_RED: rd = {16'h0000, q.droop_red};
         `A_SEL_SPEED: rd = {16'h0000, q.sel_spd};
         `A_STATUS: rd = {24'h000000, q.lim_red, q.standstill,
            q.brake_close, q.pulse_en, q.trq_mode, q.inhibit,
            q.fault, q.in_tol};
         default: rd = 32'h0000_0000;
      endcase
      d.dat = wr ? rd : q.dat;
      wd = 32'h0000_0000;
      clr = 1'b0;
      if (wr && wb_we_i) begin
         unique case (wb_adr_i)
            `A_CTRL: begin
               wd = merge(q.ctrl, wb_dat_i, wb_sel_i);
               clr = wd[`C_CLEAR];
               d.ctrl = {22'h000000, wd[9:0]};
            end
            `A_MODE: begin
               wd = merge({27'h0000000, q.mode}, wb_dat_i, wb_sel_i);
               d.mode = wd[4:0];
            end
            `A_DROOP_SCALE: d.droop_scale =
               16'(merge({16'h0000, q.droop_scale}, wb_dat_i, wb_sel_i));
            `A_MAX_SPEED: d.max_speed =
               16'(merge({16'h0000, q.max_speed}, wb_dat_i, wb_sel_i));
            `A_DEV_THR: d.dev_thr =
               16'(merge({16'h0000, q.dev_thr}, wb_dat_i, wb_sel_i));
            `A_DEV_HYST: d.dev_hyst =
               16'(merge({16'h0000, q.dev_hyst}, wb_dat_i, wb_sel_i));
            `A_DEV_DELAY: d.dev_delay =
               16'(merge({16'h0000, q.dev_delay}, wb_dat_i, wb_sel_i));
            `A_BRAKE_TIME: d.brk_time =
               16'(merge({16'h0000, q.brk_time}, wb_dat_i, wb_sel_i));
            `A_SS_THR: d.ss_thr =
               16'(merge({16'h0000, q.ss_thr}, wb_dat_i, wb_sel_i));
            `A_SS_TIME: d.ss_time =
               16'(merge({16'h0000, q.ss_time}, wb_dat_i, wb_sel_i));
            `A_QS_RAMP: d.qs_ramp =
               16'(merge({16'h0000, q.qs_ramp}, wb_dat_i, wb_sel_i));
            `A_TRQ_LIM: d.trq_lim =
               16'(merge({16'h0000, q.trq_lim}, wb_dat_i, wb_sel_i));
            `A_INERTIA: d.inertia =
               24'(merge({8'h00, q.inertia}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end

      // millisecond enable
      d.ms_tick = (q.ms_cnt == MS_LAST);
      d.ms_cnt = d.ms_tick ? 15'h0000 : q.ms_cnt + 15'h0001;

      // speed actual source
      unique case (q.ctrl[`C_SRC_HI:`C_SRC_LO])
         2'h0: act = unsmoothed_speed_actual_i;
         2'h1: act = external_speed_i;
         2'h2: act = model_speed_smoothed_i;
         default: act = encoder_speed_i;
      endcase
      d.sel_spd = act;
      d.model_spd = (q.mode == `MODE_ENC) ? encoder_speed_i
         : model_speed_smoothed_i;

      // droop
      load = q.ctrl[`C_DROOP_SRC] ? torque_setpoint_input_i
         : speed_ctrl_torque_i;
      prod = 33'(load * $signed({1'b0, q.droop_scale}));
      d.droop_red = q.ctrl[`C_DROOP_EN]
         ? prod[`DROOP_SHIFT +: 16] : 16'sh0000;

      // model versus selected actual speed deviation
      diff = 17'(act) - 17'(model_speed_smoothed_i);
      adiff = (diff < 0) ? -diff : diff;
      over = adiff > $signed({1'b0, q.dev_thr});
      if (over) begin
         d.in_tol = 1'b0;
      end else if (adiff + $signed({1'b0, q.dev_hyst})
         <= $signed({1'b0, q.dev_thr})) begin
         d.in_tol = 1'b1;
      end
      if (!over) begin
         d.dev_tmr = 16'h0000;
      end else if (q.ms_tick && q.dev_tmr < q.dev_delay) begin
         d.dev_tmr = q.dev_tmr + 16'h0001;
      end
      // trip wins over a clear in the same cycle
      d.fault = (over && q.dev_tmr >= q.dev_delay)
         || (q.fault && !clr);

      // standstill detection
      if ((q.spd_set < 0 ? -q.spd_set : q.spd_set)
         > $signed({1'b0, q.ss_thr})) begin
         d.ss_tmr = 16'h0000;
      end else if (q.ms_tick && q.ss_tmr < q.ss_time) begin
         d.ss_tmr = q.ss_tmr + 16'h0001;
      end
      stand = ((act < 0 ? -act : act) < $signed({1'b0, q.ss_thr}))
         || (q.ss_tmr >= q.ss_time);
      d.standstill = stand;

      // stop sequencing
      direct = (q.mode == `MODE_TRQ_A) || (q.mode == `MODE_TRQ_B);
      co_req = q.ctrl[`C_COAST] || (q.fault && !q.ctrl[`C_FAULT_QUICK])
         || (q.ctrl[`C_NORMAL] && direct);
      qs_req = q.ctrl[`C_QUICK] || (q.fault && q.ctrl[`C_FAULT_QUICK]);
      fol_req = q.ctrl[`C_NORMAL] && q.ctrl[`C_CHANGEOVER];
      unique case (q.st)
         drive_ctrl_pkg::ST_RUN: begin
            if (co_req) begin
               d.st = drive_ctrl_pkg::ST_OFF;
            end else if (qs_req || (q.ctrl[`C_NORMAL] && !fol_req)) begin
               d.st = drive_ctrl_pkg::ST_RAMP;
            end else if (fol_req) begin
               d.st = drive_ctrl_pkg::ST_FOLLOW;
            end
         end
         drive_ctrl_pkg::ST_RAMP, drive_ctrl_pkg::ST_FOLLOW: begin
            if (co_req) begin
               d.st = drive_ctrl_pkg::ST_OFF;
            end else if (stand) begin
               d.st = drive_ctrl_pkg::ST_BRAKE;
            end
         end
         drive_ctrl_pkg::ST_BRAKE: begin
            if (co_req || q.brk_tmr >= q.brk_time) begin
               d.st = drive_ctrl_pkg::ST_OFF;
            end
         end
         drive_ctrl_pkg::ST_OFF: begin
            if (clr && !co_req && !qs_req && !q.ctrl[`C_NORMAL]
               && !d.fault) begin
               d.st = drive_ctrl_pkg::ST_RUN;
            end
         end
      endcase
      if (q.st != drive_ctrl_pkg::ST_BRAKE) begin
         d.brk_tmr = 16'h0000;
      end else if (q.ms_tick && q.brk_tmr < q.brk_time) begin
         d.brk_tmr = q.brk_tmr + 16'h0001;
      end
      d.inhibit = (d.st == drive_ctrl_pkg::ST_OFF);
      d.pulse_en = (d.st != drive_ctrl_pkg::ST_OFF);
      d.brake_close = q.ctrl[`C_BRAKE_CFG]
         && (d.st == drive_ctrl_pkg::ST_OFF
         || d.st == drive_ctrl_pkg::ST_BRAKE);

      // torque path
      d.trq_mode = direct || (q.ctrl[`C_CHANGEOVER]
         && (q.mode == `MODE_SLESS || q.mode == `MODE_ENC));
      // no torque-mode cycle on entry, none while braking after it
      if (d.st == drive_ctrl_pkg::ST_RAMP
         || (d.st == drive_ctrl_pkg::ST_BRAKE && !q.trq_mode)) begin
         d.trq_mode = 1'b0;
      end
      base = q.trq_mode ? torque_setpoint_input_i : speed_ctrl_torque_i;
      tsum = 17'(base) + 17'(supplementary_torque_input_i);
      over_spd = act > $signed({1'b0, q.max_speed});
      under_spd = act < -$signed({1'b0, q.max_speed});
      upper = over_spd ? 17'sh00000 : $signed({1'b0, q.trq_lim});
      lower = under_spd ? 17'sh00000 : -$signed({1'b0, q.trq_lim});
      d.lim_red = over_spd || under_spd;
      if (tsum > upper) begin
         d.trq = upper[15:0];
      end else if (tsum < lower) begin
         d.trq = lower[15:0];
      end else begin
         d.trq = sat(tsum);
      end

      // open-loop torque integrator
      integ = (q.mode == `MODE_SLESS) && q.trq_mode && open_loop_i;
      tdiv = $signed({8'h00, q.inertia});
      if (tdiv == 0) begin
         tdiv = 32'sh0000_0001;
      end
      if (!integ) begin
         d.int_acc = 32'sh0000_0000;
         d.int_sp = q.spd_set;
      end else if (q.ms_tick) begin
         d.int_acc = q.int_acc + 32'(q.trq);
         if (q.int_acc >= tdiv) begin
            d.int_acc = q.int_acc - tdiv + 32'(q.trq);
            d.int_sp = sat(17'(q.int_sp) + 17'sh00001);
         end else if (q.int_acc <= -tdiv) begin
            d.int_acc = q.int_acc + tdiv + 32'(q.trq);
            d.int_sp = sat(17'(q.int_sp) - 17'sh00001);
         end
      end

      // quick stop ramp toward zero
      if (q.st != drive_ctrl_pkg::ST_RAMP
         && q.st != drive_ctrl_pkg::ST_BRAKE) begin
         d.ramp_sp = q.spd_set;
      end else if (q.ms_tick) begin
         if (q.ramp_sp > $signed({1'b0, q.qs_ramp})) begin
            d.ramp_sp = sat(17'(q.ramp_sp) - $signed({1'b0, q.qs_ramp}));
         end else if (q.ramp_sp < -$signed({1'b0, q.qs_ramp})) begin
            d.ramp_sp = sat(17'(q.ramp_sp) + $signed({1'b0, q.qs_ramp}));
         end else begin
            d.ramp_sp = 16'sh0000;
         end
      end
      if (q.st == drive_ctrl_pkg::ST_OFF) begin
         d.spd_set = 16'sh0000;
      end else if (q.st == drive_ctrl_pkg::ST_RAMP
         || q.st == drive_ctrl_pkg::ST_BRAKE) begin
         d.spd_set = q.ramp_sp;
      end else if (integ) begin
         d.spd_set = q.int_sp;
      end else begin
         d.spd_set = sat(17'(speed_setpoint_i) - 17'(q.droop_red));
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.st <= drive_ctrl_pkg::ST_OFF;
         q.inhibit <= 1'b1;
         q.in_tol <= 1'b1;
         q.ctrl <= `RST_CTRL;
         q.mode <= `RST_MODE;
         q.trq_lim <= `RST_TRQ_LIM;
         q.max_speed <= `RST_MAX_SPEED;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign speed_setpoint_o = q.spd_set;
   assign speed_actual_o = q.sel_spd;
   assign motor_model_speed_o = q.model_spd;
   assign torque_demand_o = q.trq;
   assign torque_mode_o = q.trq_mode;
   assign pulse_enable_o = q.pulse_en;
   assign brake_close_o = q.brake_close;
   assign switch_on_inhibit_o = q.inhibit;
   assign fault_o = q.fault;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_coast;
      q.st == drive_ctrl_pkg::ST_RUN && q.ctrl[`C_COAST]
         |=> !pulse_enable_o && switch_on_inhibit_o;
   endproperty
   a_coast: assert property (p_coast)
      else $error("coast stop did not cut pulses");
   property p_coast_brake;
      q.st == drive_ctrl_pkg::ST_RUN && q.ctrl[`C_COAST]
         && q.ctrl[`C_BRAKE_CFG] |=> brake_close_o;
   endproperty
   a_coast_brake: assert property (p_coast_brake)
      else $error("brake not closed on coast stop");
   property p_inhibit;
      q.st == drive_ctrl_pkg::ST_OFF |-> q.inhibit && !q.pulse_en;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("stop ended without switch-on inhibit");
   property p_quick;
      q.st == drive_ctrl_pkg::ST_RAMP ##1 q.st == drive_ctrl_pkg::ST_RAMP
         |-> !torque_mode_o;
   endproperty
   a_quick: assert property (p_quick)
      else $error("torque mode during quick stop");
   property p_brake_wait;
      q.st == drive_ctrl_pkg::ST_BRAKE && !co_req
         ##1 q.st == drive_ctrl_pkg::ST_OFF
         |-> $past(q.brk_tmr) >= q.brk_time;
   endproperty
   a_brake_wait: assert property (p_brake_wait)
      else $error("pulses inhibited before brake time");
   property p_droop_off;
      !q.ctrl[`C_DROOP_EN] |=> q.droop_red == 16'sh0000;
   endproperty
   a_droop_off: assert property (p_droop_off)
      else $error("droop reduction while disabled");
   property p_fault;
      over && q.dev_tmr >= q.dev_delay |=> fault_o;
   endproperty
   a_fault: assert property (p_fault)
      else $error("deviation fault not raised");
   property p_tol;
      over |=> !q.in_tol;
   endproperty
   a_tol: assert property (p_tol)
      else $error("in tolerance while deviation exceeds band");
   property p_restart;
      !over |=> q.dev_tmr == 16'h0000;
   endproperty
   a_restart: assert property (p_restart)
      else $error("deviation timer not restarted");
   property p_direct;
      q.st == drive_ctrl_pkg::ST_RUN && q.ctrl[`C_NORMAL] && direct
         |=> q.st == drive_ctrl_pkg::ST_OFF;
   endproperty
   a_direct: assert property (p_direct)
      else $error("normal stop in direct torque not coast");
   property p_limit;
      over_spd |=> torque_demand_o <= 16'sh0000;
   endproperty
   a_limit: assert property (p_limit)
      else $error("positive torque above max speed");

   c_coast: cover property (q.st == drive_ctrl_pkg::ST_RUN
      ##1 q.st == drive_ctrl_pkg::ST_OFF);
   c_quick: cover property (q.st == drive_ctrl_pkg::ST_RAMP
      ##[1:1000] q.st == drive_ctrl_pkg::ST_BRAKE
      ##[1:1000] q.st == drive_ctrl_pkg::ST_OFF);
   c_fault: cover property ($rose(q.fault));
   c_follow: cover property (q.st == drive_ctrl_pkg::ST_FOLLOW);
endmodule

// >>> testbench/drive_speed_torque_stop_control_tb_top.sv
`include "drive_ctrl_map.svh"
module drive_speed_torque_stop_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [4:0] mode;
      logic co;
      logic [1:0] src;
      logic tm;
   } row_type;
   logic ref_clk_i, rst_n_i, cyc, stb, we, ack, tmo, pen, brk, inh, flt, ol;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic signed [15:0] sp, unsm, ext, msm, enc, sct, tsp, sup, spo, sao;
   logic signed [15:0] mmo, tdo, e;
   int error_cnt = 0;
   int n_checks = 0;
   int n;
   row_type rows [6] = '{'{5'h14, 1'b0, 2'h0, 1'b0},
      '{5'h14, 1'b1, 2'h1, 1'b1}, '{5'h15, 1'b1, 2'h2, 1'b1},
      '{5'h16, 1'b0, 2'h3, 1'b1}, '{5'h17, 1'b0, 2'h0, 1'b1},
      '{5'h15, 1'b0, 2'h3, 1'b0}};
   drive_ctrl #(.MS_CYCLES(4)) drive_ctrl_i (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .speed_setpoint_i(sp),
      .unsmoothed_speed_actual_i(unsm), .external_speed_i(ext),
      .model_speed_smoothed_i(msm), .encoder_speed_i(enc),
      .speed_ctrl_torque_i(sct), .torque_setpoint_input_i(tsp),
      .supplementary_torque_input_i(sup), .open_loop_i(ol),
      .speed_setpoint_o(spo), .speed_actual_o(sao),
      .motor_model_speed_o(mmo), .torque_demand_o(tdo),
      .torque_mode_o(tmo), .pulse_enable_o(pen), .brake_close_o(brk),
      .switch_on_inhibit_o(inh), .fault_o(flt));
   power_stage_model power_stage_model_i (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .pulse_enable_i(pen), .brake_close_i(brk),
      .speed_setpoint_i(spo), .unsmoothed_speed_o(unsm),
      .encoder_speed_o(enc));
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do @(posedge ref_clk_i); while (ack !== 1'b1 && ++k < 50);
      q = rdat;
      if (k == 50) error_cnt++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic tk(input int c);
      repeat (c) @(posedge ref_clk_i);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #800000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      {cyc, stb, we, adr, sel, wdat} <= '0;
      rst_n_i <= 1'b0;
      ol <= 1'b0;
      sp <= 16'sh0300;
      ext <= 16'sh0050;
      msm <= 16'sh0050;
      sct <= 16'sh0100;
      tsp <= 16'sh0040;
      sup <= 16'sh0080;
      tk(2);
      rst_n_i <= 1'b1;
      tk(1);
      chk(inh, 1'b1);
      chk(pen, 1'b0);
      wb(1'b0, `A_MODE, 32'h0);
      chk(q, 32'h15);
      wb(1'b0, `A_CTRL, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 8'h80, 32'h0);
      chk(q, 32'h0);
      // wide band first: model and actual differ at start
      wb(1'b1, `A_DEV_THR, 32'h7fff);
      // first clear drops stop bits and fault, second enters run
      wb(1'b1, `A_CTRL, 32'h400);
      wb(1'b1, `A_CTRL, 32'h400);
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, `A_MODE, 32'(rows[i].mode));
         wb(1'b1, `A_CTRL, {22'h0, rows[i].src, 5'h0, rows[i].co, 2'h0});
         tk(3);
         e = rows[i].src == 2'h0 ? unsm : rows[i].src == 2'h1 ? ext :
            rows[i].src == 2'h2 ? msm : enc;
         chk(sao, e);
         wb(1'b0, `A_SEL_SPEED, 32'h0);
         chk(q[15:0], e);
         chk(mmo, rows[i].mode == 5'h15 ? enc : msm);
         chk(tmo, rows[i].tm);
         chk(tdo, rows[i].tm ? tsp + sup : sct + sup);
      end
      $display("test modes done");
      wb(1'b1, `A_MODE, 32'h15);
      wb(1'b1, `A_DROOP_SCALE, 32'h100);
      wb(1'b1, `A_CTRL, 32'h1);
      tk(3);
      chk(spo, 16'sh0200);
      wb(1'b0, `A_DROOP_RED, 32'h0);
      chk(q[15:0], 16'h0100);
      wb(1'b1, `A_CTRL, 32'h0);
      sct <= 16'sh0300;
      wb(1'b1, `A_TRQ_LIM, 32'h100);
      tk(3);
      chk(tdo, 16'sh0100);
      wb(1'b1, `A_MAX_SPEED, 32'h20);
      tk(3);
      wb(1'b0, `A_STATUS, 32'h0);
      chk(q[7], 1'b1);
      chk(tdo, 32'h0);
      wb(1'b1, `A_MAX_SPEED, 32'h7000);
      wb(1'b1, `A_TRQ_LIM, 32'h4000);
      $display("test droop limit done");
      ol <= 1'b1;
      wb(1'b1, `A_MODE, 32'h14);
      wb(1'b1, `A_CTRL, 32'h4);
      tk(40);
      chk(spo > 16'sh0300, 1'b1);
      ol <= 1'b0;
      wb(1'b1, `A_CTRL, 32'h0);
      wb(1'b1, `A_MODE, 32'h15);
      $display("test integrator done");
      wb(1'b1, `A_QS_RAMP, 32'h100);
      wb(1'b1, `A_SS_THR, 32'h10);
      wb(1'b1, `A_SS_TIME, 32'h40);
      wb(1'b1, `A_BRAKE_TIME, 32'h2);
      wb(1'b1, `A_CTRL, 32'h64);
      tk(3);
      chk(tmo, 1'b0);
      n = 0;
      while (brk !== 1'b1 && n < 400) begin
         tk(1);
         n++;
      end
      chk(brk, 1'b1);
      chk(pen, 1'b1);
      chk(spo, 16'sh0000);
      n = 0;
      while (inh !== 1'b1 && n < 400) begin
         tk(1);
         n++;
      end
      tk(1);
      chk(pen, 1'b0);
      chk(inh, 1'b1);
      $display("test quick stop done");
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, `A_MODE, i ? 32'h16 : 32'h15);
         wb(1'b1, `A_CTRL, 32'h400);
         wb(1'b1, `A_CTRL, 32'h400);
         tk(2);
         chk(pen, 1'b1);
         wb(1'b1, `A_CTRL, i ? 32'h48 : 32'h50);
         tk(2);
         chk(pen, 1'b0);
         chk(brk, 1'b1);
         chk(inh, 1'b1);
      end
      $display("test coast done");
      wb(1'b1, `A_MODE, 32'h15);
      sp <= 16'sh0000;
      wb(1'b1, `A_CTRL, 32'h400);
      wb(1'b1, `A_CTRL, 32'h400);
      wb(1'b1, `A_CTRL, 32'h4c);
      tk(1);
      chk(pen, 1'b1);
      chk(tmo, 1'b1);
      n = 0;
      while (inh !== 1'b1 && n < 400) begin
         tk(1);
         n++;
      end
      chk(inh, 1'b1);
      $display("test follow done");
      wb(1'b1, `A_MODE, 32'h15);
      wb(1'b1, `A_CTRL, 32'h500);
      wb(1'b1, `A_CTRL, 32'h500);
      wb(1'b1, `A_DEV_THR, 32'h40);
      wb(1'b1, `A_DEV_HYST, 32'h10);
      wb(1'b1, `A_DEV_DELAY, 32'h2);
      for (int i = 0; i < 2; i++) begin
         ext <= msm - 16'sh0080;
         tk(3);
         ext <= msm;
         tk(3);
      end
      chk(flt, 1'b0);
      wb(1'b0, `A_STATUS, 32'h0);
      chk(q[0], 1'b1);
      ext <= msm + 16'sh0080;
      n = 0;
      while (flt !== 1'b1 && n < 100) begin
         tk(1);
         n++;
      end
      chk(flt, 1'b1);
      tk(3);
      chk(pen, 1'b0);
      wb(1'b0, `A_STATUS, 32'h0);
      chk(q[0], 1'b0);
      $display("test deviation done");
      end_of_test;
   end
endmodule

// >>> testbench/power_stage_model.sv
module power_stage_model (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic pulse_enable_i,
   input wire logic brake_close_i,
   input wire logic signed [15:0] speed_setpoint_i,
   output logic signed [15:0] unsmoothed_speed_o,
   output logic signed [15:0] encoder_speed_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [15:0] spd;
   // shaft tracks the one shared setpoint, coasts down without pulses
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || brake_close_i)
         spd <= 16'sh0000;
      else if (pulse_enable_i)
         spd <= speed_setpoint_i;
      else
         spd <= spd - (spd >>> 2);
   end
   assign unsmoothed_speed_o = spd;
   // encoder count sits two lsb off the unsmoothed value
   assign encoder_speed_o = spd + 16'sh0002;
endmodule
